// [logic/linear_sensor_pulse_timer.sv]
// Purpose: Eight-channel magnetostrictive sensor excitation and echo timing, APB slave
// Assumes: APB master per AMBA rules; echo inputs asynchronous to mclk_i
// Notes: Zero-wait APB; read data registered in the setup cycle
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module linear_sensor_pulse_timer #(
  parameter int unsigned CH_NUM = sensor_timer_pkg::CH_NUM
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [sensor_timer_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sensor pins
  input wire logic [CH_NUM-1:0] echo_phase_a_input_i,
  output logic [CH_NUM-1:0] excitation_pulse_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by read and write paths

  function automatic logic echo_phase_a_input_hit(input logic [sensor_timer_pkg::ADDR_W-1:0] a);
    echo_phase_a_input_hit = a[11:7] == 5'h00 && a[1:0] == 2'h0 && 32'(a[6:4]) < CH_NUM;
  endfunction : echo_phase_a_input_hit

  function automatic logic [2:0] echo_phase_a_input_idx(input logic [sensor_timer_pkg::ADDR_W-1:0] a);
    echo_phase_a_input_idx = a[6:4];
  endfunction : echo_phase_a_input_idx

  // Generator clock halves with each increment of the select code
  function automatic logic [sensor_timer_pkg::PHASE_W-1:0] step_of(input logic [sensor_timer_pkg::SEL_W-1:0] s);
    step_of = sensor_timer_pkg::PGEN_STEP >> s;
  endfunction : step_of

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [sensor_timer_pkg::ACC_W-1:0] freq_r [CH_NUM];
  logic [sensor_timer_pkg::ACC_W-1:0] freq_nxt [CH_NUM];
  logic [sensor_timer_pkg::FBSEL_W-1:0] fbsel_r [CH_NUM];
  logic [sensor_timer_pkg::FBSEL_W-1:0] fbsel_nxt [CH_NUM];
  logic [sensor_timer_pkg::SEL_W-1:0] sel_r [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::SEL_W-1:0] sel_nxt [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::WIDTH_W-1:0] width_r [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::WIDTH_W-1:0] width_nxt [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::PHASE_W-1:0] phase_r [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::PHASE_W-1:0] phase_nxt [sensor_timer_pkg::GROUP_NUM];
  logic [sensor_timer_pkg::GROUP_NUM-1:0] tick_r, tick_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [sensor_timer_pkg::LATCH_W-1:0] latch_w [CH_NUM];
  logic [sensor_timer_pkg::EDGE_W-1:0] edges_w [CH_NUM];

  logic setup, wr_take;
  logic [sensor_timer_pkg::PHASE_W:0] phase_sum [sensor_timer_pkg::GROUP_NUM];

  assign setup = psel_i && !penable_i;
  assign wr_take = psel_i && penable_i && pwrite_i && !pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Generator clock ticks, one phase accumulator per group

  always_comb begin
    for (int g = 0; g < sensor_timer_pkg::GROUP_NUM; g++) begin
      phase_sum[g] = {1'b0, phase_r[g]} + {1'b0, step_of(sel_r[g])};
      phase_nxt[g] = phase_sum[g][sensor_timer_pkg::PHASE_W-1:0];
      tick_nxt[g] = phase_sum[g][sensor_timer_pkg::PHASE_W];
    end
  end

  always_ff @(posedge mclk_i) begin
    for (int g = 0; g < sensor_timer_pkg::GROUP_NUM; g++) begin
      if (reset_i) begin
        phase_r[g] <= '0;
      end else begin
        phase_r[g] <= phase_nxt[g];
      end
    end
    if (reset_i) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_comb begin
    for (int c = 0; c < CH_NUM; c++) begin
      freq_nxt[c] = freq_r[c];
      fbsel_nxt[c] = fbsel_r[c];
    end
    for (int g = 0; g < sensor_timer_pkg::GROUP_NUM; g++) begin
      sel_nxt[g] = sel_r[g];
      width_nxt[g] = width_r[g];
    end
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    // Error and read data fixed in setup so both come from flops
    if (setup) begin
      prdata_nxt = '0;
      pslverr_nxt = 1'b0;
      if (echo_phase_a_input_hit(paddr_i)) begin
        unique case (paddr_i[3:0])
          sensor_timer_pkg::FREQ_OFS: prdata_nxt = 32'(freq_r[echo_phase_a_input_idx(paddr_i)]);
          sensor_timer_pkg::FBSEL_OFS: prdata_nxt = 32'(fbsel_r[echo_phase_a_input_idx(paddr_i)]);
          sensor_timer_pkg::LATCH_OFS: begin
            prdata_nxt = 32'(latch_w[echo_phase_a_input_idx(paddr_i)]);
            pslverr_nxt = pwrite_i;
          end
          sensor_timer_pkg::EDGES_OFS: begin
            prdata_nxt = 32'(edges_w[echo_phase_a_input_idx(paddr_i)]);
            pslverr_nxt = pwrite_i;
          end
          default: pslverr_nxt = 1'b1;
        endcase
      end else begin
        unique case (paddr_i)
          sensor_timer_pkg::SEL_LOW_ADDR: prdata_nxt = 32'(sel_r[0]);
          sensor_timer_pkg::SEL_HIGH_ADDR: prdata_nxt = 32'(sel_r[1]);
          sensor_timer_pkg::WIDTH_LOW_ADDR: prdata_nxt = 32'(width_r[0]);
          sensor_timer_pkg::WIDTH_HIGH_ADDR: prdata_nxt = 32'(width_r[1]);
          default: pslverr_nxt = 1'b1;
        endcase
      end
    end
    if (wr_take) begin
      if (echo_phase_a_input_hit(paddr_i)) begin
        if (paddr_i[3:0] == sensor_timer_pkg::FREQ_OFS) begin
          freq_nxt[echo_phase_a_input_idx(paddr_i)] = pwdata_i[sensor_timer_pkg::ACC_W-1:0];
        end
        if (paddr_i[3:0] == sensor_timer_pkg::FBSEL_OFS) begin
          fbsel_nxt[echo_phase_a_input_idx(paddr_i)] = pwdata_i[sensor_timer_pkg::FBSEL_W-1:0];
        end
      end else begin
        unique case (paddr_i)
          sensor_timer_pkg::SEL_LOW_ADDR: sel_nxt[0] = pwdata_i[sensor_timer_pkg::SEL_W-1:0];
          sensor_timer_pkg::SEL_HIGH_ADDR: sel_nxt[1] = pwdata_i[sensor_timer_pkg::SEL_W-1:0];
          sensor_timer_pkg::WIDTH_LOW_ADDR: width_nxt[0] = pwdata_i[sensor_timer_pkg::WIDTH_W-1:0];
          sensor_timer_pkg::WIDTH_HIGH_ADDR: width_nxt[1] = pwdata_i[sensor_timer_pkg::WIDTH_W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int c = 0; c < CH_NUM; c++) begin
        freq_r[c] <= sensor_timer_pkg::FREQ_RST;
        fbsel_r[c] <= sensor_timer_pkg::FBSEL_RST;
      end
      for (int g = 0; g < sensor_timer_pkg::GROUP_NUM; g++) begin
        sel_r[g] <= sensor_timer_pkg::SEL_RST;
        width_r[g] <= sensor_timer_pkg::WIDTH_RST;
      end
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else begin
      freq_r <= freq_nxt;
      fbsel_r <= fbsel_nxt;
      sel_r <= sel_nxt;
      width_r <= width_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r && psel_i && penable_i;
  assign pready_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < CH_NUM; c++) begin : g_echo_phase_a_input
    sensor_channel u_echo_phase_a_input (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .tick_i(tick_r[c / sensor_timer_pkg::GROUP_SIZE]),
      .freq_cmd_i(freq_r[c]),
      .width_i(width_r[c / sensor_timer_pkg::GROUP_SIZE]),
      .timer_mode_i(fbsel_r[c] == sensor_timer_pkg::FBSEL_TIMER),
      .echo_i(echo_phase_a_input_i[c]),
      .pulse_o(excitation_pulse_out_o[c]),
      .latch_o(latch_w[c]),
      .edge_count_o(edges_w[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_group_defaults;
    @(posedge mclk_i)
    !reset_i && $past(reset_i) |-> sel_r[0] == sensor_timer_pkg::SEL_RST && sel_r[1] == sensor_timer_pkg::SEL_RST &&
      width_r[0] == sensor_timer_pkg::WIDTH_RST && width_r[1] == sensor_timer_pkg::WIDTH_RST;
  endproperty
  a_group_defaults: assert property (p_group_defaults) else $error("group settings not at default");

  property p_tick_rate;
    @(posedge mclk_i) disable iff (reset_i)
    tick_r[0] |=> !tick_r[0] ##1 !tick_r[0] ##1 !tick_r[0] ##1 !tick_r[0] ##1 !tick_r[0] ##1 !tick_r[0]
      ##1 !tick_r[0] ##1 !tick_r[0];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("generator tick faster than default");

endmodule : linear_sensor_pulse_timer

// [logic/sensor_timer_pkg.sv]
// Purpose: Shared constants for the linear sensor pulse timer
// Assumes: 100 MHz system clock, APB register access
// Notes: Rates are realised as phase steps on the system clock
package sensor_timer_pkg;

  // Clock and rates
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned PGEN_HZ = 9_830_000;
  localparam longint unsigned TIMER_HZ = 117_960_000;

  // Counts and widths
  localparam int unsigned CH_NUM = 8;
  localparam int unsigned GROUP_SIZE = 4;
  localparam int unsigned GROUP_NUM = 2;
  localparam int unsigned ACC_W = 24;
  localparam int unsigned PHASE_W = 24;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned WIDTH_W = 8;
  localparam int unsigned FBSEL_W = 4;
  localparam int unsigned LATCH_W = 24;
  localparam int unsigned TFRAC_W = 8;
  localparam int unsigned EDGE_W = 16;
  localparam int unsigned ADDR_W = 12;

  // Phase steps per system clock
  localparam logic [PHASE_W-1:0] PGEN_STEP = PHASE_W'((PGEN_HZ << PHASE_W) / CLK_HZ);
  localparam logic [15:0] TIMER_STEP = 16'((TIMER_HZ << TFRAC_W) / CLK_HZ);

  // Register offsets
  localparam logic [3:0] FREQ_OFS = 4'h0;
  localparam logic [3:0] FBSEL_OFS = 4'h4;
  localparam logic [3:0] LATCH_OFS = 4'h8;
  localparam logic [3:0] EDGES_OFS = 4'hc;
  localparam logic [ADDR_W-1:0] SEL_LOW_ADDR = 12'h100;
  localparam logic [ADDR_W-1:0] SEL_HIGH_ADDR = 12'h104;
  localparam logic [ADDR_W-1:0] WIDTH_LOW_ADDR = 12'h108;
  localparam logic [ADDR_W-1:0] WIDTH_HIGH_ADDR = 12'h10c;

  // Reset values and codes
  localparam logic [ACC_W-1:0] FREQ_RST = 24'h000000;
  localparam logic [FBSEL_W-1:0] FBSEL_RST = 4'h0;
  localparam logic [FBSEL_W-1:0] FBSEL_TIMER = 4'hc;
  localparam logic [WIDTH_W-1:0] WIDTH_RST = 8'h0f;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

endpackage : sensor_timer_pkg

// [logic/sensor_channel.sv]
// Purpose: One channel: pulse frequency generator, excitation width, echo timer
// Assumes: tick_i is a one-cycle pulse at the pulse generator rate
// Notes: Timer counts in units of the fast timer rate via a fractional step
`timescale 1ns/100ps
module sensor_channel (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Settings
  input wire logic tick_i,
  input wire logic [sensor_timer_pkg::ACC_W-1:0] freq_cmd_i,
  input wire logic [sensor_timer_pkg::WIDTH_W-1:0] width_i,
  input wire logic timer_mode_i,
  // Sensor pins
  input wire logic echo_i,
  output logic pulse_o,
  // Results
  output logic [sensor_timer_pkg::LATCH_W-1:0] latch_o,
  output logic [sensor_timer_pkg::EDGE_W-1:0] edge_count_o
);

  localparam int unsigned TW = sensor_timer_pkg::LATCH_W + sensor_timer_pkg::TFRAC_W;

  logic [sensor_timer_pkg::ACC_W-1:0] acc_r, acc_nxt;
  logic [sensor_timer_pkg::WIDTH_W-1:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic s1_r, s2_r, s3_r;
  logic armed_r, armed_nxt;
  logic [TW-1:0] timer_r, timer_nxt;
  logic [sensor_timer_pkg::LATCH_W-1:0] latch_r, latch_nxt;
  logic [sensor_timer_pkg::EDGE_W-1:0] edges_r, edges_nxt;
  logic [sensor_timer_pkg::ACC_W:0] acc_sum;
  logic carry, echo_rise;

  assign acc_sum = {1'b0, acc_r} + {1'b0, freq_cmd_i};
  assign carry = tick_i && acc_sum[sensor_timer_pkg::ACC_W];
  assign echo_rise = s2_r && !s3_r;

  always_comb begin
    acc_nxt = tick_i ? acc_sum[sensor_timer_pkg::ACC_W-1:0] : acc_r;
    cnt_nxt = cnt_r;
    if (carry && cnt_r == '0) begin
      cnt_nxt = width_i;
    end else if (tick_i && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    pulse_nxt = cnt_nxt != '0;
    armed_nxt = armed_r;
    timer_nxt = armed_r ? timer_r + TW'(sensor_timer_pkg::TIMER_STEP) : timer_r;
    latch_nxt = latch_r;
    // Edges while the excitation is high are not latched (still counted): not yet armed
    if (armed_r && echo_rise) begin
      latch_nxt = timer_r[TW-1:sensor_timer_pkg::TFRAC_W];
      armed_nxt = 1'b0;
    end
    // Edges decoded here, not by assigns, to keep the block free of a feedback path
    if (!pulse_r && pulse_nxt) begin
      armed_nxt = 1'b0;
    end
    if (pulse_r && !pulse_nxt && timer_mode_i) begin
      armed_nxt = 1'b1;
      timer_nxt = '0;
    end
    edges_nxt = echo_rise ? edges_r + 1'b1 : edges_r;
  end

  always_ff @(posedge mclk_i) begin
    s1_r <= echo_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (reset_i) begin
      acc_r <= '0;
      cnt_r <= '0;
      pulse_r <= 1'b0;
      armed_r <= 1'b0;
      timer_r <= '0;
      latch_r <= '0;
      edges_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
      armed_r <= armed_nxt;
      timer_r <= timer_nxt;
      latch_r <= latch_nxt;
      edges_r <= edges_nxt;
    end
  end

  assign pulse_o = pulse_r;
  assign latch_o = latch_r;
  assign edge_count_o = edges_r;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_fall_timed;
    $fell(pulse_o) && $past(timer_mode_i);
  endsequence

  property p_accum;
    @(posedge mclk_i) disable iff (reset_i)
    tick_i |=> acc_r == $past(acc_sum[sensor_timer_pkg::ACC_W-1:0]);
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator did not add command");

  property p_wrap;
    @(posedge mclk_i) disable iff (reset_i)
    carry |=> acc_r < $past(acc_r);
  endproperty
  a_wrap: assert property (p_wrap) else $error("accumulator did not wrap");

  property p_pulse_start;
    @(posedge mclk_i) disable iff (reset_i)
    carry && !pulse_o && width_i != '0 |=> pulse_o && cnt_r == $past(width_i);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("overflow gave no pulse");

  property p_arm;
    @(posedge mclk_i) disable iff (reset_i)
    s_fall_timed |-> armed_r && timer_r == '0 ##1 timer_r == TW'(sensor_timer_pkg::TIMER_STEP);
  endproperty
  a_arm: assert property (p_arm) else $error("timer not cleared at excitation fall");

  property p_latch;
    @(posedge mclk_i) disable iff (reset_i)
    armed_r && echo_rise |=> !armed_r && latch_o == $past(timer_r[TW-1:sensor_timer_pkg::TFRAC_W]);
  endproperty
  a_latch: assert property (p_latch) else $error("timer not latched on echo edge");

  property p_hold;
    @(posedge mclk_i) disable iff (reset_i)
    !$past(armed_r && echo_rise) |-> $stable(latch_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without echo edge");

  property p_edges;
    @(posedge mclk_i) disable iff (reset_i)
    echo_rise |=> edge_count_o == $past(edge_count_o) + 1'b1;
  endproperty
  a_edges: assert property (p_edges) else $error("edge counter missed an edge");

endmodule : sensor_channel

// [verification/sensor_echo_model.sv]
// Purpose: Sensor model that answers each excitation with echo pulses
// Assumes: Mode 0 two-pulse return (three with extra_i), 1 single-pulse return, 2 silent
// Notes: Delay counts clock edges after the excitation falls
`timescale 1ns/100ps
module sensor_echo_model (
  // Clock
  input wire logic mclk_i,
  // Bench control
  input wire logic [1:0] mode_i,
  input wire logic [31:0] delay_i,
  input wire logic extra_i,
  // Sensor pins
  input wire logic excite_i,
  output logic echo_o = 1'b0,
  output int edges_o = 0
);
  task automatic blip();
    echo_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    echo_o <= 1'b0;
  endtask : blip

  initial begin
    forever begin
      @(posedge excite_i);
      repeat (2) @(posedge mclk_i);
      // Start pulse sits well inside the excitation width
      if (mode_i == 2'h0) blip();
      if (mode_i == 2'h1) echo_o <= 1'b0;
      @(negedge excite_i);
      repeat (delay_i) @(posedge mclk_i);
      if (mode_i == 2'h0) blip();
      // Inverted wiring turns the stop edge into a rising one
      if (mode_i == 2'h1) echo_o <= 1'b1;
      if (mode_i == 2'h0 && extra_i) begin
        repeat (20) @(posedge mclk_i);
        blip();
      end
    end
  end

  always @(posedge echo_o) edges_o <= edges_o + 1;
endmodule : sensor_echo_model

// [verification/linear_sensor_pulse_timer_bench.sv]
// Purpose: Self-checking bench for the sensor pulse timer
// Assumes: Sensor model on channel 0, other echo inputs idle
// Notes: Rates are checked within three clocks of generator jitter
`timescale 1ns/100ps
module linear_sensor_pulse_timer_bench;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] excite;
  logic echo0;
  logic [1:0] mode = 2'h0;
  logic extra = 1'b1;
  int dly = 100;
  int edges;
  int failures = 0;
  int total_checks = 0;
  int last_exp = 0;
  int w;
  int p;
  real t0;

  linear_sensor_pulse_timer i_dut (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .echo_phase_a_input_i({7'h00, echo0}),
    .excitation_pulse_out_o(excite)
  );

  sensor_echo_model i_model (
    .mclk_i(mclk_i),
    .mode_i(mode),
    .delay_i(dly),
    .extra_i(extra),
    .excite_i(excite[0]),
    .echo_o(echo0),
    .edges_o(edges)
  );

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Unknown bits make the window test fail, so they never pass
  task automatic near(input logic [31:0] seen, input int exp, input int tol);
    check(((seen - 32'(exp) + 32'(tol)) <= 32'(2 * tol)) ? 32'(exp) : seen, 32'(exp));
  endtask : near

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(wr, a, d, rd, err);
    if (!wr) check(rd, exp);
    check(32'(err), 32'(exp_err));
  endtask : access

  task automatic wait_lvl(input logic lvl, input int ch, output int n);
    n = 0;
    while (excite[ch] !== lvl) begin
      @(posedge mclk_i);
      n++;
      if (n > 30000) begin
        failures++;
        final_report();
      end
    end
  endtask : wait_lvl

  // Width of one pulse and the span of three whole periods
  task automatic measure(input int ch);
    int n;
    // Start from low so a pulse already under way is not half counted
    wait_lvl(1'b0, ch, n);
    wait_lvl(1'b1, ch, n);
    wait_lvl(1'b0, ch, w);
    p = w;
    for (int i = 0; i < 5; i++) begin
      wait_lvl(i % 2 == 0, ch, n);
      p += n;
    end
  endtask : measure

  // One excitation frame, then latched time and edge count
  task automatic frame(input bit upd);
    int n;
    logic [31:0] rd;
    logic err;
    wait_lvl(1'b1, 0, n);
    wait_lvl(1'b0, 0, n);
    repeat (dly + 60) @(posedge mclk_i);
    if (upd) last_exp = ((dly + 3) * int'(sensor_timer_pkg::TIMER_STEP)) / 256;
    apb(1'b0, 12'h008, 32'h0, rd, err);
    near(rd, last_exp, 4);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    check(rd, 32'(edges[15:0]));
  endtask : frame

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(17));
    t0 = 2.0 ** 24 / real'(sensor_timer_pkg::PGEN_STEP);
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    access(1'b0, 12'h000, 0, 32'h0, 1'b0);
    access(1'b0, 12'h004, 0, 32'h0, 1'b0);
    access(1'b0, sensor_timer_pkg::SEL_LOW_ADDR, 0, 32'h0, 1'b0);
    access(1'b0, sensor_timer_pkg::SEL_HIGH_ADDR, 0, 32'h0, 1'b0);
    access(1'b0, sensor_timer_pkg::WIDTH_LOW_ADDR, 0, 32'h0f, 1'b0);
    access(1'b0, sensor_timer_pkg::WIDTH_HIGH_ADDR, 0, 32'h0f, 1'b0);
    access(1'b0, 12'h200, 0, 32'h0, 1'b1);
    access(1'b1, 12'h008, 32'h55, 32'h0, 1'b1);
    access(1'b0, 12'h008, 0, 32'h0, 1'b0);
    // A command that does not divide the range exercises the kept remainder
    access(1'b1, 12'h000, 32'h18000, 32'h0, 1'b0);
    access(1'b1, 12'h040, 32'h18000, 32'h0, 1'b0);
    measure(0);
    near(32'(w), int'(15.0 * t0), 3);
    near(32'(p), int'(512.0 * t0), 3);
    measure(4);
    near(32'(p), int'(512.0 * t0), 3);
    access(1'b1, sensor_timer_pkg::WIDTH_HIGH_ADDR, 32'h05, 32'h0, 1'b0);
    measure(4);
    near(32'(w), int'(5.0 * t0), 3);
    access(1'b1, sensor_timer_pkg::SEL_LOW_ADDR, 32'h1, 32'h0, 1'b0);
    measure(0);
    near(32'(p), int'(1024.0 * t0), 3);
    access(1'b1, sensor_timer_pkg::SEL_LOW_ADDR, 32'h0, 32'h0, 1'b0);
    access(1'b1, 12'h004, 32'(sensor_timer_pkg::FBSEL_TIMER), 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      mode <= 2'(i % 2);
      dly <= 100 + int'($urandom % 900);
      frame(1'b1);
    end
    mode <= 2'h2;
    frame(1'b0);
    access(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
    mode <= 2'h0;
    dly <= 700;
    frame(1'b0);
    final_report();
  end
endmodule : linear_sensor_pulse_timer_bench
